/* logic/tmrw_timer.sv */
// Purpose: 8-bit timer with clear-on-match, fast and phase-correct PWM, two channels.
// Assumes: Timer source is the system clock; pin direction bits live in control.
// Notes: Reads return data the cycle after the read strobe; flags clear by writing one.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE_01) Low top in CLEAR_ON_MATCH_MODE wraps via 0xFF
// (RULE_02) CLEAR_ON_MATCH_MODE top writes apply immediately
// (RULE_03) CLEAR_ON_MATCH_MODE raises compare A flag at top
// (RULE_04) CLEAR_ON_MATCH_MODE mode 1 toggles output A
// (RULE_05) Pin driven only when direction is output
// (RULE_06) CLEAR_ON_MATCH_MODE overflow flag on MAX to zero
// (RULE_07) Prescale 1,8,32,64,128,256,1024
// (RULE_08) Modes 3,7 run fast PWM
// (RULE_09) Fast top 0xFF or compare A
// (RULE_10) Fast counts to top, then bottom
// (RULE_11) Fast: clear match set bottom, or reverse
// (RULE_12) Mode two non-inverted, three inverted
// (RULE_13) Fast overflow flag at top
// (RULE_14) Fast extremes: spike or constant level
// (RULE_15) Fast mode 1 toggles, buffered compare; the code toggles output A only, B holds its level
// (RULE_16) Fast fixed top period 256 ticks
// (RULE_17) Modes 1,5 run phase-correct PWM
// (RULE_18) Phase-correct clears up, sets down
// (RULE_19) Phase-correct holds top one tick
// (RULE_20) Phase-correct overflow flag at bottom
// (RULE_21) Phase-correct extremes give constant levels
// (RULE_22) Phase-correct symmetry transition at bottom
// (RULE_23) Phase-correct fixed top period 510 ticks
// (RULE_24) Mode 2 clears count on compare A
// (RULE_25) Compare flag set next tick
// (RULE_26) PWM compare update at top/bottom
// (RULE_27) Phase-correct top 0xFF or compare A
module tmrw_timer
   import tmrw_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // Register port
   input wire tmrw_bus_s bus_in,
   output logic [31:0] rdata_out,
   // Interrupt requests
   output logic ovf_irq_out,
   output logic cmpa_irq_out,
   output logic cmpb_irq_out,
   // Compare output pins
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe_n_out
);
   logic [31:0] ctrl_r;
   logic [7:0] cmp_buf_r [2];
   logic [7:0] cmp_act_r [2];
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic down_r;
   logic [2:0] flags_r;
   logic [2:0] ien_r;
   logic [1:0] oc_r;
   logic [TMRW_PRE_W-1:0] pre_r;
   logic cnt_wr_blk_r;
   logic [2:0] wgm;
   logic [2:0] cs;
   logic [1:0] com [2];
   logic tick;
   logic [7:0] top;
   tmrw_mode_e mode;
   logic pwm;
   logic at_top;
   logic at_bot;
   logic [1:0] match;
   logic wr_ctrl, wr_cmpa, wr_cmpb, wr_cnt, wr_flags, wr_ien;

   assign wgm = ctrl_r[TMRW_CTRL_WGM_LSB +: 3];
   assign cs = ctrl_r[TMRW_CTRL_CS_LSB +: 3];
   assign com[0] = ctrl_r[TMRW_CTRL_COMA_LSB +: 2];
   assign com[1] = ctrl_r[TMRW_CTRL_COMB_LSB +: 2];
   assign wr_ctrl = bus_in.wr && (bus_in.addr == TMRW_OFF_CTRL);
   assign wr_cmpa = bus_in.wr && (bus_in.addr == TMRW_OFF_CMPA);
   assign wr_cmpb = bus_in.wr && (bus_in.addr == TMRW_OFF_CMPB);
   assign wr_cnt = bus_in.wr && (bus_in.addr == TMRW_OFF_CNT);
   assign wr_flags = bus_in.wr && (bus_in.addr == TMRW_OFF_FLAGS);
   assign wr_ien = bus_in.wr && (bus_in.addr == TMRW_OFF_IEN);

   always_comb
   begin
      case (wgm)
         TMRW_WGM_FAST_FF, TMRW_WGM_FAST_A: mode = TMRW_MODE_FAST; // [RULE_08]
         TMRW_WGM_PC_FF, TMRW_WGM_PC_A: mode = TMRW_MODE_PC; // [RULE_17]
         default: mode = TMRW_MODE_NORMAL;
      endcase
   end
   assign pwm = (mode != TMRW_MODE_NORMAL);

   // Top: fixed 0xFF, or compare A for CLEAR_ON_MATCH_MODE and the A-topped PWM modes
   always_comb
   begin
      case (wgm)
         TMRW_WGM_CTC: top = cmp_act_r[0]; // [RULE_24]
         TMRW_WGM_FAST_A, TMRW_WGM_PC_A: top = cmp_act_r[0]; // [RULE_09] [RULE_27]
         default: top = TMRW_MAX;
      endcase
   end

   // Prescaler taps: free-running divider, one tick per wrap of the chosen tap
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         pre_r <= '0;
      else
         pre_r <= pre_r + 1'b1;
   end
   always_comb
   begin
      case (cs) // [RULE_07]
         3'h1: tick = 1'b1;
         3'h2: tick = (pre_r[2:0] == 3'h7);
         3'h3: tick = (pre_r[4:0] == 5'h1F);
         3'h4: tick = (pre_r[5:0] == 6'h3F);
         3'h5: tick = (pre_r[6:0] == 7'h7F);
         3'h6: tick = (pre_r[7:0] == 8'hFF);
         3'h7: tick = (pre_r == 10'h3FF);
         default: tick = 1'b0;
      endcase
   end

   assign at_top = (cnt_r == top);
   assign at_bot = (cnt_r == TMRW_BOTTOM);
   // A count write blocks matches for the next tick
   assign match[0] = (cnt_r == cmp_act_r[0]) && !cnt_wr_blk_r;
   assign match[1] = (cnt_r == cmp_act_r[1]) && !cnt_wr_blk_r;

   always_comb
   begin
      cnt_nxt = cnt_r + 8'h01;
      case (mode)
         TMRW_MODE_FAST:
            if (at_top)
               cnt_nxt = TMRW_BOTTOM; // [RULE_10] [RULE_16]
         TMRW_MODE_PC:
            if (down_r)
               cnt_nxt = at_bot ? 8'h01 : cnt_r - 8'h01; // [RULE_23]
            else if (at_top)
               cnt_nxt = cnt_r - 8'h01; // [RULE_19]
         default:
            // Missed low top runs on past 0xFF to 0x00
            if (wgm == TMRW_WGM_CTC && at_top)
               cnt_nxt = TMRW_BOTTOM; // [RULE_01] [RULE_24]
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         cnt_r <= TMRW_BOTTOM;
      else if (wr_cnt)
         cnt_r <= bus_in.wdata[7:0];
      else if (tick)
         cnt_r <= cnt_nxt;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         cnt_wr_blk_r <= 1'b0;
      else if (wr_cnt)
         cnt_wr_blk_r <= 1'b1;
      else if (tick)
         cnt_wr_blk_r <= 1'b0;
   end

   // Direction is down after the top tick, up after bottom
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         down_r <= 1'b0;
      else if (mode != TMRW_MODE_PC)
         down_r <= 1'b0;
      else if (tick && at_top)
         down_r <= 1'b1; // [RULE_19]
      else if (tick && at_bot)
         down_r <= 1'b0;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         ctrl_r <= TMRW_CTRL_RST;
      else if (wr_ctrl)
         ctrl_r <= {18'h0, bus_in.wdata[13:0]};
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         ien_r <= '0;
      else if (wr_ien)
         ien_r <= bus_in.wdata[2:0];
   end

   // Compare: buffer loads on write; active copy follows at once outside PWM
   for (genvar i = 0; i < 2; i++)
   begin : g_cmp
      always_ff @(posedge clk_sys_in)
      begin
         if (srst_in)
            cmp_buf_r[i] <= TMRW_CMP_RST;
         else if (i == 0 ? wr_cmpa : wr_cmpb)
            cmp_buf_r[i] <= bus_in.wdata[7:0];
      end
      always_ff @(posedge clk_sys_in)
      begin
         if (srst_in)
            cmp_act_r[i] <= TMRW_CMP_RST;
         else if (!pwm && (i == 0 ? wr_cmpa : wr_cmpb))
            cmp_act_r[i] <= bus_in.wdata[7:0]; // [RULE_02]
         else if (pwm && tick && ((mode == TMRW_MODE_FAST && at_top)
               || (mode == TMRW_MODE_PC && at_top && !down_r)))
            cmp_act_r[i] <= cmp_buf_r[i]; // [RULE_26] [RULE_15]
         else if (!pwm)
            cmp_act_r[i] <= cmp_buf_r[i];
      end

      // Output waveform register
      always_ff @(posedge clk_sys_in)
      begin
         if (srst_in)
            oc_r[i] <= 1'b0;
         else if (tick)
         begin
            case (mode)
               TMRW_MODE_FAST:
                  if (com[i] == TMRW_COM_TOGGLE)
                  begin
                     if (i == 0 && match[i])
                        oc_r[i] <= !oc_r[i]; // [RULE_15]
                  end
                  else if (com[i][1])
                  begin
                     // Match to MAX wins over bottom so level stays constant
                     if (match[i])
                        oc_r[i] <= com[i][0]; // [RULE_11] [RULE_12] [RULE_14]
                     else if (at_top)
                        oc_r[i] <= !com[i][0]; // [RULE_11]
                  end
               TMRW_MODE_PC:
                  if (com[i][1])
                  begin
                     if (match[i] && cmp_act_r[i] == TMRW_MAX)
                        oc_r[i] <= !com[i][0]; // [RULE_21]
                     else if (match[i] && cmp_act_r[i] == TMRW_BOTTOM)
                        oc_r[i] <= com[i][0]; // [RULE_21]
                     else if (match[i])
                        oc_r[i] <= down_r ? !com[i][0] : com[i][0]; // [RULE_18] [RULE_12]
                     else if (at_bot && down_r == 1'b1 && cnt_r < cmp_act_r[i])
                        oc_r[i] <= !com[i][0]; // [RULE_22]
                     else if (cnt_r == 8'h01 && down_r && cmp_act_r[i] == TMRW_BOTTOM)
                        oc_r[i] <= com[i][0];
                  end
               default:
                  if (match[i])
                     case (com[i])
                        TMRW_COM_TOGGLE: oc_r[i] <= !oc_r[i]; // [RULE_04]
                        TMRW_COM_NONINV: oc_r[i] <= 1'b0;
                        TMRW_COM_INV: oc_r[i] <= 1'b1;
                        default: oc_r[i] <= oc_r[i];
                     endcase
            endcase
         end
      end
   end

   // Flags: hardware set wins over a write-one clear in the same cycle
   logic [2:0] flag_set;
   always_comb
   begin
      flag_set = '0;
      if (tick)
      begin
         flag_set[TMRW_FLG_CMPA] = match[0]; // [RULE_25] [RULE_03]
         flag_set[TMRW_FLG_CMPB] = match[1]; // [RULE_25]
         case (mode)
            TMRW_MODE_FAST: flag_set[TMRW_FLG_OVF] = at_top; // [RULE_13]
            TMRW_MODE_PC: flag_set[TMRW_FLG_OVF] = at_bot && down_r; // [RULE_20]
            default: flag_set[TMRW_FLG_OVF] = (cnt_r == TMRW_MAX); // [RULE_06]
         endcase
      end
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         flags_r <= '0;
      else
         flags_r <= (flags_r & ~(wr_flags ? bus_in.wdata[2:0] : 3'h0)) | flag_set;
   end

   assign ovf_irq_out = flags_r[TMRW_FLG_OVF] & ien_r[TMRW_FLG_OVF];
   assign cmpa_irq_out = flags_r[TMRW_FLG_CMPA] & ien_r[TMRW_FLG_CMPA]; // [RULE_03]
   assign cmpb_irq_out = flags_r[TMRW_FLG_CMPB] & ien_r[TMRW_FLG_CMPB];

   // Pin drives only with direction set to output and a compare mode chosen
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         pin_out <= 2'b00;
         pin_oe_n_out <= 2'b11;
      end
      else
      begin
         pin_out <= oc_r;
         pin_oe_n_out[0] <= !(ctrl_r[TMRW_CTRL_DIRA] && com[0] != TMRW_COM_OFF); // [RULE_05]
         pin_oe_n_out[1] <= !(ctrl_r[TMRW_CTRL_DIRB] && com[1] != TMRW_COM_OFF); // [RULE_05]
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         rdata_out <= '0;
      else if (bus_in.rd)
         case (bus_in.addr)
            TMRW_OFF_CTRL: rdata_out <= ctrl_r;
            TMRW_OFF_CMPA: rdata_out <= {24'h0, cmp_buf_r[0]};
            TMRW_OFF_CMPB: rdata_out <= {24'h0, cmp_buf_r[1]};
            TMRW_OFF_CNT: rdata_out <= {24'h0, cnt_r};
            TMRW_OFF_FLAGS: rdata_out <= {29'h0, flags_r};
            TMRW_OFF_IEN: rdata_out <= {29'h0, ien_r};
            default: rdata_out <= '0;
         endcase
      else
         rdata_out <= '0;
   end

   chk_ctc_wrap: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_24]
      (tick && wgm == TMRW_WGM_CTC && at_top && !wr_cnt) |=> cnt_r == TMRW_BOTTOM)
      else $error("count not cleared at compare top");
   chk_fast_wrap: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_10]
      (tick && mode == TMRW_MODE_FAST && at_top && !wr_cnt) |=> cnt_r == TMRW_BOTTOM)
      else $error("fast count did not restart");
   chk_pc_turn: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_19]
      (tick && mode == TMRW_MODE_PC && at_top && !down_r && !wr_cnt && !wr_ctrl)
      |=> down_r && cnt_r == $past(cnt_r) - 8'h01)
      else $error("phase count failed to turn");
   chk_fast_ovf: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_13]
      (tick && mode == TMRW_MODE_FAST && at_top) |=> flags_r[TMRW_FLG_OVF])
      else $error("fast overflow flag missing");
   chk_pc_ovf: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_20]
      (tick && mode == TMRW_MODE_PC && at_bot && down_r) |=> flags_r[TMRW_FLG_OVF])
      else $error("phase overflow flag missing");
   chk_cmpa_flag: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_25]
      (tick && match[0]) |=> flags_r[TMRW_FLG_CMPA])
      else $error("compare flag not set");
   chk_ctc_toggle: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_04]
      (tick && mode == TMRW_MODE_NORMAL && match[0] && com[0] == TMRW_COM_TOGGLE)
      |=> oc_r[0] != $past(oc_r[0]))
      else $error("output did not toggle");
   chk_pin_dir: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_05]
      !ctrl_r[TMRW_CTRL_DIRA] && !wr_ctrl |=> pin_oe_n_out[0])
      else $error("pin driven while input");
   chk_ctc_direct: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RULE_02]
      (wr_cmpa && !pwm && !wr_ctrl) |=> cmp_act_r[0] == $past(bus_in.wdata[7:0]))
      else $error("compare write not direct");
endmodule // tmrw_timer
`default_nettype wire

/* pkg/tmrw_pkg.sv */
// Purpose: Shared constants and types for the 8-bit waveform timer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on a plain strobe port.
`default_nettype none
package tmrw_pkg;
   localparam logic [7:0] TMRW_BOTTOM = 8'h00;
   localparam logic [7:0] TMRW_MAX = 8'hFF;
   // Register offsets (byte addresses)
   localparam logic [7:0] TMRW_OFF_CTRL = 8'h00;
   localparam logic [7:0] TMRW_OFF_CMPA = 8'h04;
   localparam logic [7:0] TMRW_OFF_CMPB = 8'h08;
   localparam logic [7:0] TMRW_OFF_CNT = 8'h0C;
   localparam logic [7:0] TMRW_OFF_FLAGS = 8'h10;
   localparam logic [7:0] TMRW_OFF_IEN = 8'h14;
   // Control field positions
   localparam int TMRW_CTRL_WGM_LSB = 0;
   localparam int TMRW_CTRL_CS_LSB = 4;
   localparam int TMRW_CTRL_COMA_LSB = 8;
   localparam int TMRW_CTRL_COMB_LSB = 10;
   localparam int TMRW_CTRL_DIRA = 12;
   localparam int TMRW_CTRL_DIRB = 13;
   // Flag bit positions
   localparam int TMRW_FLG_OVF = 0;
   localparam int TMRW_FLG_CMPA = 1;
   localparam int TMRW_FLG_CMPB = 2;
   // Reset values
   localparam logic [31:0] TMRW_CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] TMRW_CMP_RST = 8'h00;
   // Waveform modes
   localparam logic [2:0] TMRW_WGM_NORMAL = 3'h0;
   localparam logic [2:0] TMRW_WGM_PC_FF = 3'h1;
   localparam logic [2:0] TMRW_WGM_CTC = 3'h2;
   localparam logic [2:0] TMRW_WGM_FAST_FF = 3'h3;
   localparam logic [2:0] TMRW_WGM_PC_A = 3'h5;
   localparam logic [2:0] TMRW_WGM_FAST_A = 3'h7;
   // Compare output modes
   localparam logic [1:0] TMRW_COM_OFF = 2'h0;
   localparam logic [1:0] TMRW_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TMRW_COM_NONINV = 2'h2;
   localparam logic [1:0] TMRW_COM_INV = 2'h3;
   // Prescaler selects: 0 stop, 1..7 = /1,/8,/32,/64,/128,/256,/1024
   localparam int TMRW_PRE_W = 10;
   typedef enum logic [2:0] {
      TMRW_MODE_NORMAL = 3'b001,
      TMRW_MODE_FAST = 3'b010,
      TMRW_MODE_PC = 3'b100
   } tmrw_mode_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } tmrw_bus_s;
endpackage : tmrw_pkg
`default_nettype wire

/* test/test_timer8_waveform_modes.sv */
// Purpose: Self-checking bench for the waveform timer.
// Assumes: Prescaler /1 except in the prescale test; pads seen through the pin model.
// Notes: Waveform widths are timed between pad edges with a free cycle counter.
`timescale 1ns/1ps
`default_nettype none
module test_timer8_waveform_modes;
   import tmrw_pkg::*;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   tmrw_bus_s bus_in = '0;
   logic [31:0] rdata_out;
   logic ovf_irq_out;
   logic cmpa_irq_out;
   logic cmpb_irq_out;
   logic [1:0] pin_out;
   logic [1:0] pin_oe_n_out;
   logic [1:0] pad;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   tmrw_timer dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .bus_in(bus_in),
      .rdata_out(rdata_out), .ovf_irq_out(ovf_irq_out), .cmpa_irq_out(cmpa_irq_out),
      .cmpb_irq_out(cmpb_irq_out), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));
   tmrw_pin_model pin_u (.clk_sys_in(clk_sys_in), .pin_in(pin_out),
      .pin_oe_n_in(pin_oe_n_out), .pad_out(pad));
   always #4 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) cyc <= cyc + 1;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] wgm, input logic [2:0] cs,
                                       input logic [1:0] ca, input logic [1:0] cb);
      logic [31:0] v;
      v = 32'h0;
      v[TMRW_CTRL_WGM_LSB +: 3] = wgm;
      v[TMRW_CTRL_CS_LSB +: 3] = cs;
      v[TMRW_CTRL_COMA_LSB +: 2] = ca;
      v[TMRW_CTRL_COMB_LSB +: 2] = cb;
      v[TMRW_CTRL_DIRA] = 1'b1;
      v[TMRW_CTRL_DIRB] = (cb != TMRW_COM_OFF);
      return v;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_in);
      bus_in.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_in);
      bus_in.rd <= 1'b0;
      #1;
      d = rdata_out;
   endtask
   task automatic wait_chg(input int ch, output int t);
      logic lv;
      int n;
      #1;
      lv = pad[ch];
      n = 0;
      while (pad[ch] === lv && n < 3000)
      begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      if (n >= 3000)
      begin
         chk("pad change wait", 32'h1, 32'h0);
         close_out();
      end
      t = cyc;
   endtask
   // Settles first: compare writes may wait for a top in PWM modes
   task automatic pwm(input int ch, output int hi, output int per);
      int ta, tb, tc;
      repeat (1024) @(posedge clk_sys_in);
      wait_chg(ch, ta);
      if (pad[ch] !== 1'b1)
         wait_chg(ch, ta);
      wait_chg(ch, tb);
      wait_chg(ch, tc);
      hi = tb - ta;
      per = tc - ta;
   endtask
   task automatic hi_cnt(input int ch, input int n, output int h);
      h = 0;
      repeat (1024) @(posedge clk_sys_in);
      repeat (n)
      begin
         @(posedge clk_sys_in);
         #1;
         h += int'(pad[ch] === 1'b1);
      end
   endtask
   task automatic t_reset();
      logic [31:0] d;
      #1;
      chk("oe_n at reset", 32'(pin_oe_n_out), 32'h3);
      chk("pin at reset", 32'(pin_out), 32'h0);
      rd(TMRW_OFF_CTRL, d);
      chk("ctrl reset", d, TMRW_CTRL_RST);
      rd(TMRW_OFF_CMPA, d);
      chk("cmpa reset", d, 32'(TMRW_CMP_RST));
      wr(8'hFC, 32'hFFFF_FFFF);
      rd(8'hFC, d);
      chk("unmapped read", d, 32'h0);
      $display("Test reset done");
   endtask
   task automatic t_ctc();
      int t0, t1, t2;
      logic [31:0] d;
      wr(TMRW_OFF_IEN, 32'h7);
      wr(TMRW_OFF_CMPA, 32'h80);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_CTC, 3'h1, TMRW_COM_TOGGLE, TMRW_COM_OFF));
      // Pin enables are registered one clock behind the control write
      @(posedge clk_sys_in);
      #1;
      chk("ctc enables", 32'(pin_oe_n_out), 32'h2);
      wait_chg(0, t0);
      wait_chg(0, t1);
      chk("ctc toggle gap", t1 - t0, 32'h81);
      wr(TMRW_OFF_FLAGS, 32'h7);
      repeat (16) @(posedge clk_sys_in);
      wr(TMRW_OFF_CMPA, 32'h10);
      wait_chg(0, t2);
      chk("missed match wrap", t2 - t1, 32'h111);
      rd(TMRW_OFF_FLAGS, d);
      chk("overflow at wrap", 32'(d[TMRW_FLG_OVF]), 32'h1);
      wr(TMRW_OFF_FLAGS, 32'h7);
      wait_chg(0, t0);
      chk("new top at once", t0 - t2, 32'h11);
      rd(TMRW_OFF_FLAGS, d);
      chk("no overflow at top", 32'(d[TMRW_FLG_OVF]), 32'h0);
      chk("compare a flag", 32'(d[TMRW_FLG_CMPA]), 32'h1);
      chk("compare a request", 32'(cmpa_irq_out), 32'h1);
      $display("Test clear on match done");
   endtask
   task automatic t_pre();
      int t0, t1;
      int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
      wr(TMRW_OFF_CMPA, 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_CTC, 3'(i + 1), TMRW_COM_TOGGLE, TMRW_COM_OFF));
         wait_chg(0, t0);
         wait_chg(0, t0);
         wait_chg(0, t1);
         chk("prescaled toggle gap", t1 - t0, dv[i]);
      end
      $display("Test prescale done");
   endtask
   task automatic t_fast();
      int hi, per;
      logic [31:0] d;
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_FAST_FF, 3'h1, TMRW_COM_NONINV, TMRW_COM_OFF));
      wr(TMRW_OFF_CMPA, 32'h40);
      pwm(0, hi, per);
      chk("fast high time", hi, 32'h41);
      chk("fast period", per, 32'h100);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_FAST_FF, 3'h1, TMRW_COM_INV, TMRW_COM_OFF));
      pwm(0, hi, per);
      chk("fast inverted high", hi, 32'hBF);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_FAST_A, 3'h1, TMRW_COM_OFF, TMRW_COM_NONINV));
      wr(TMRW_OFF_CMPA, 32'h1F);
      wr(TMRW_OFF_CMPB, 32'h0F);
      chk("fast enables", 32'(pin_oe_n_out), 32'h1);
      pwm(1, hi, per);
      chk("top a high time", hi, 32'h10);
      chk("top a period", per, 32'h20);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_FAST_A, 3'h1, TMRW_COM_TOGGLE, TMRW_COM_NONINV));
      pwm(0, hi, per);
      chk("fast toggle high", hi, 32'h20);
      chk("fast toggle period", per, 32'h40);
      wr(TMRW_OFF_FLAGS, 32'h7);
      repeat (40) @(posedge clk_sys_in);
      rd(TMRW_OFF_FLAGS, d);
      chk("fast overflow", 32'(d[TMRW_FLG_OVF]), 32'h1);
      chk("compare b request", 32'(cmpb_irq_out), 32'h1);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_FAST_FF, 3'h1, TMRW_COM_NONINV, TMRW_COM_OFF));
      wr(TMRW_OFF_CMPA, 32'hFF);
      hi_cnt(0, 512, hi);
      // Match at MAX wins over the bottom set, so non-inverted stays low
      chk("fast max level", hi, 32'h0);
      wr(TMRW_OFF_CMPA, 32'h0);
      hi_cnt(0, 512, hi);
      chk("fast bottom spikes", hi, 32'h2);
      $display("Test fast done");
   endtask
   task automatic t_pc();
      int hi, per;
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_PC_FF, 3'h1, TMRW_COM_NONINV, TMRW_COM_OFF));
      wr(TMRW_OFF_CMPA, 32'h40);
      wr(TMRW_OFF_CNT, 32'h0);
      pwm(0, hi, per);
      chk("dual high time", hi, 32'h80);
      chk("dual period", per, 32'h1FE);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_PC_FF, 3'h1, TMRW_COM_INV, TMRW_COM_OFF));
      pwm(0, hi, per);
      chk("dual inverted high", hi, 32'h17E);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_PC_FF, 3'h1, TMRW_COM_NONINV, TMRW_COM_OFF));
      wr(TMRW_OFF_CMPA, 32'h0);
      hi_cnt(0, 1020, hi);
      chk("dual bottom level", hi, 32'h0);
      wr(TMRW_OFF_CMPA, 32'hFF);
      hi_cnt(0, 1020, hi);
      chk("dual max level", hi, 32'h3FC);
      wr(TMRW_OFF_IEN, 32'h1);
      wr(TMRW_OFF_FLAGS, 32'h7);
      repeat (600) @(posedge clk_sys_in);
      chk("dual overflow request", 32'(ovf_irq_out), 32'h1);
      wr(TMRW_OFF_CTRL, ctl(TMRW_WGM_PC_A, 3'h1, TMRW_COM_OFF, TMRW_COM_NONINV));
      wr(TMRW_OFF_CMPA, 32'h20);
      wr(TMRW_OFF_CMPB, 32'h10);
      pwm(1, hi, per);
      chk("dual top a high", hi, 32'h20);
      chk("dual top a period", per, 32'h40);
      $display("Test phase correct done");
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      t_reset();
      t_ctc();
      t_pre();
      t_fast();
      t_pc();
      close_out();
   end
endmodule // test_timer8_waveform_modes
`default_nettype wire

/* test/tmrw_pin_model.sv */
// Purpose: Pad model for the two compare output pins of the timer.
// Assumes: No pull resistors on either pad.
// Notes: A released pad flips every clock, so a stale level never passes as driven.
`timescale 1ns/1ps
`default_nettype none
module tmrw_pin_model
(
   // Clock
   input wire logic clk_sys_in,
   // Timer pin side
   input wire logic [1:0] pin_in,
   input wire logic [1:0] pin_oe_n_in,
   // Resolved pad levels
   output logic [1:0] pad_out
);
   logic float_r = 1'b0;
   always @(posedge clk_sys_in)
   begin
      float_r <= ~float_r;
   end
   always_comb
   begin
      pad_out[0] = pin_oe_n_in[0] ? float_r : pin_in[0];
      pad_out[1] = pin_oe_n_in[1] ? ~float_r : pin_in[1];
   end
endmodule // tmrw_pin_model
`default_nettype wire
